// ==== fci_map.svh ====
// constants for the flash command host: command codes, status bits, timing counts
// assumes a 100 MHz controller clock and an 8-bit command path on the low data byte
`ifndef FCI_MAP_SVH
`define FCI_MAP_SVH
`define FCI_CMD_READ_ARRAY 8'hFF
`define FCI_CMD_READ_ID 8'h90
`define FCI_CMD_READ_STATUS 8'h70
`define FCI_CMD_CLEAR_STATUS 8'h50
`define FCI_CMD_ERASE_SETUP 8'h20
`define FCI_CMD_CONFIRM 8'hD0
`define FCI_CMD_WRITE_SETUP 8'h40
`define FCI_CMD_WRITE_SETUP_ALT 8'h10
`define FCI_CMD_RESUME 8'hD0
// suspend code is a parameter default of the top, value arbitrary
`define FCI_CMD_SUSPEND_DEF 8'h5A
`define FCI_ID_MAKER_ADDR 20'h00000
`define FCI_ID_DEVICE_ADDR 20'h00001
`define FCI_SR_READY 7
`define FCI_SR_ERASE_ERR 5
`define FCI_SR_PROG_ERR 4
`define FCI_SR_LOW_SUPPLY 3
`define FCI_SR_BOOT_LOCK 1
`define FCI_SR_AFTER_WAKE 8'h80
`define FCI_ERASED_WORD 16'hFFFF
`define FCI_BLOCK_HI 19
`define FCI_BLOCK_LO 12
// strobe timing: each strobe phase lasts this long
`define FCI_CLK_NS 10
`define FCI_PHASE_NS 70
`define FCI_PHASE_CYC ((`FCI_PHASE_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`endif

// ==== fci_pkg.sv ====
// types shared by the flash command host
// assumes fci_map.svh for the numeric constants
package fci_pkg;
    // user operations accepted on the command port
    typedef enum logic [2:0] {
        FCI_OP_READ_ARRAY,
        FCI_OP_READ_ID,
        FCI_OP_READ_STATUS,
        FCI_OP_CLEAR_STATUS,
        FCI_OP_ERASE,
        FCI_OP_PROGRAM,
        FCI_OP_SUSPEND,
        FCI_OP_RESUME
    } fci_op_t;
    // bus cycle kinds driven by the strobe engine
    typedef enum logic [1:0] {
        FCI_CYC_WRITE,
        FCI_CYC_READ
    } fci_cyc_t;
endpackage

// ==== fci_bus_cycle.sv ====
// one asynchronous flash bus cycle: write or read, fixed strobe phases
// assumes the caller holds address and data stable for the whole cycle
`timescale 1ns/1ps
`include "fci_map.svh"
module fci_bus_cycle
    import fci_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire fci_cyc_t kind_i,
    input wire logic [15:0] rd_pin_i,
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic dq_oe_o,
    output logic [15:0] rd_data_o,
    output logic done_o
);
    typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} fci_bc_t;
    fci_bc_t st_r; // cycle phase
    logic [7:0] cnt_r; // phase timer
    fci_cyc_t kind_r; // latched cycle kind
    wire phase_end = (cnt_r == 8'h00); // timer ran out
    // phase sequencing; strobe falls in setup end, rises at strobe end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= BC_IDLE;
            cnt_r <= 8'h00;
            kind_r <= FCI_CYC_WRITE;
            ce_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            we_n_o <= 1'b1;
            dq_oe_o <= 1'b0;
            rd_data_o <= 16'h0000;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (st_r)
                BC_IDLE: begin
                    if (start_i) begin
                        kind_r <= kind_i;
                        ce_n_o <= 1'b0;
                        dq_oe_o <= (kind_i == FCI_CYC_WRITE);
                        cnt_r <= 8'(`FCI_PHASE_CYC - 1);
                        st_r <= BC_SETUP;
                    end
                end
                BC_SETUP: begin
                    if (phase_end) begin
                        // oe and we never low together
                        oe_n_o <= (kind_r != FCI_CYC_READ); // R21
                        we_n_o <= (kind_r != FCI_CYC_WRITE); // R21
                        cnt_r <= 8'(`FCI_PHASE_CYC - 1);
                        st_r <= BC_STROBE;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                BC_STROBE: begin
                    if (phase_end) begin
                        // we rises before ce: device latches here
                        we_n_o <= 1'b1; // R19
                        oe_n_o <= 1'b1; // R5
                        rd_data_o <= rd_pin_i;
                        cnt_r <= 8'(`FCI_PHASE_CYC - 1);
                        st_r <= BC_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                default: begin
                    if (phase_end) begin
                        // strobes high again before any next read
                        ce_n_o <= 1'b1; // R5
                        dq_oe_o <= 1'b0;
                        done_o <= 1'b1;
                        st_r <= BC_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
            endcase
        end
    end
endmodule

// ==== fci_host.sv ====
// host controller driving an asynchronous boot-block flash over its pins
// assumes the flash pins are asynchronous; ready/busy and dq are synchronised
// Behaviour
// R1: FFH returns device to array read
// R2: array read ignored while busy unsuspended
// R3: 90H then read 0 or 1 gives ids
// R4: 70H makes reads return status byte
// R5: strobe high between reads refreshes status
// R6: error flags only cleared by 50H
// R7: clear status useless while suspended
// R8: read commands work at any supply
// R9: erase is 20H then D0H, same block
// R10: block chosen by address bits 19..12
// R11: erased block reads FFFFH throughout
// R12: after erase reads return status byte
// R13: erase done seen on pin and bit7
// R14: ready/busy low only while operation runs
// R15: broken erase sequence sets bits 4,5
// R16: low supply erase sets bits 3,5
// R17: locked boot erase sets bits 1,5
// R18: write setup is 40H or 10H
// R19: data latched at first rising strobe
// R20: suspend and resume single writes
// R21: never oe and we low together
// R22: check erase error, clear first
// R23: low supply program sets bits 3,4
// R24: wake from powerdown gives status 80H
`timescale 1ns/1ps
`include "fci_map.svh"
module fci_host
    import fci_pkg::*;
#(
    parameter logic [7:0] SUSPEND_CODE = `FCI_CMD_SUSPEND_DEF // arbitrary value
)
(
    input wire logic REF_CLK_I,
    input wire logic ARST_N_I,
    input wire logic REQ_I,
    input wire fci_op_t OP_I,
    input wire logic [19:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    output logic BUSY_O,
    output logic DONE_O,
    output logic [15:0] RDATA_O,
    output logic [7:0] STATUS_O,
    output logic ERR_O,
    output logic FLASH_BUSY_O,
    input wire logic READY_BUSY_OUTPUT_N_I,
    input wire logic [15:0] DQ_I,
    output logic [15:0] DQ_O,
    output logic DQ_OE_O,
    output logic [19:0] A_O,
    output logic CE_N_O,
    output logic OE_N_O,
    output logic WE_N_O
);
    typedef enum logic [2:0] {
        H_IDLE, H_CMD1, H_CMD2, H_READ, H_POLL_CMD, H_POLL_RD
    } fci_hst_t;
    fci_hst_t st_r; // sequence state
    fci_op_t op_r; // operation in progress
    logic [19:0] addr_r; // target address
    logic [15:0] wdat_r; // write value
    logic [1:0] rst_sync_r; // reset release
    logic [1:0] rb_sync_r; // ready/busy synchroniser
    logic [15:0] dq_s1_r; // data synchroniser stage 1
    logic [15:0] dq_s2_r; // data synchroniser stage 2
    logic cyc_start_r; // start one bus cycle
    fci_cyc_t cyc_kind_r; // kind of that cycle
    logic [15:0] bc_rd; // sampled read data
    logic bc_done; // bus cycle finished
    logic bc_ce_n; // strobes from the engine
    logic bc_oe_n;
    logic bc_we_n;
    logic bc_dq_oe;
    wire rst_n = rst_sync_r[1]; // released reset copy
    wire [7:0] sr_byte = bc_rd[7:0]; // status byte on low lane
    wire sr_ready = sr_byte[`FCI_SR_READY]; // R13
    // any error bit in a returned status byte
    wire sr_err = sr_byte[`FCI_SR_ERASE_ERR] | sr_byte[`FCI_SR_PROG_ERR]
                | sr_byte[`FCI_SR_LOW_SUPPLY] | sr_byte[`FCI_SR_BOOT_LOCK];
    // first command byte of an operation
    function automatic logic [7:0] first_cmd(input fci_op_t op);
        case (op)
            FCI_OP_READ_ARRAY: first_cmd = `FCI_CMD_READ_ARRAY; // R1
            FCI_OP_READ_ID: first_cmd = `FCI_CMD_READ_ID; // R3
            FCI_OP_READ_STATUS: first_cmd = `FCI_CMD_READ_STATUS; // R4
            FCI_OP_CLEAR_STATUS: first_cmd = `FCI_CMD_CLEAR_STATUS; // R6
            FCI_OP_ERASE: first_cmd = `FCI_CMD_ERASE_SETUP; // R9
            FCI_OP_PROGRAM: first_cmd = `FCI_CMD_WRITE_SETUP; // R18
            FCI_OP_SUSPEND: first_cmd = SUSPEND_CODE; // R20
            default: first_cmd = `FCI_CMD_RESUME; // R20
        endcase
    endfunction
    // reset release through two flops
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    // pin synchronisers; first stage read only by second
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            rb_sync_r <= 2'b11;
            dq_s1_r <= 16'h0000;
            dq_s2_r <= 16'h0000;
        end else begin
            rb_sync_r <= {rb_sync_r[0], READY_BUSY_OUTPUT_N_I};
            dq_s1_r <= DQ_I;
            dq_s2_r <= dq_s1_r;
        end
    end
    fci_bus_cycle u_cyc (
        .clk_i(REF_CLK_I),
        .rst_n_i(rst_n),
        .start_i(cyc_start_r),
        .kind_i(cyc_kind_r),
        .rd_pin_i(dq_s2_r),
        .ce_n_o(bc_ce_n),
        .oe_n_o(bc_oe_n),
        .we_n_o(bc_we_n),
        .dq_oe_o(bc_dq_oe),
        .rd_data_o(bc_rd),
        .done_o(bc_done)
    );
    // pin registers follow the engine
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            CE_N_O <= 1'b1;
            OE_N_O <= 1'b1;
            WE_N_O <= 1'b1;
            DQ_OE_O <= 1'b0;
            FLASH_BUSY_O <= 1'b0;
        end else begin
            CE_N_O <= bc_ce_n;
            OE_N_O <= bc_oe_n;
            WE_N_O <= bc_we_n;
            DQ_OE_O <= bc_dq_oe;
            FLASH_BUSY_O <= ~rb_sync_r[1]; // R14
        end
    end
    // operation sequencer
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= H_IDLE;
            op_r <= FCI_OP_READ_ARRAY;
            addr_r <= 20'h00000;
            wdat_r <= 16'h0000;
            cyc_start_r <= 1'b0;
            cyc_kind_r <= FCI_CYC_WRITE;
            BUSY_O <= 1'b0;
            DONE_O <= 1'b0;
            RDATA_O <= 16'h0000;
            STATUS_O <= `FCI_SR_AFTER_WAKE; // R24
            ERR_O <= 1'b0;
            A_O <= 20'h00000;
            DQ_O <= 16'h0000;
        end else begin
            cyc_start_r <= 1'b0;
            DONE_O <= 1'b0;
            case (st_r)
                H_IDLE: begin
                    if (REQ_I) begin
                        op_r <= OP_I;
                        addr_r <= ADDR_I;
                        wdat_r <= WDATA_I;
                        A_O <= ADDR_I; // R10
                        DQ_O <= {8'h00, first_cmd(OP_I)};
                        cyc_kind_r <= FCI_CYC_WRITE;
                        cyc_start_r <= 1'b1;
                        BUSY_O <= 1'b1;
                        ERR_O <= 1'b0;
                        st_r <= H_CMD1;
                    end
                end
                H_CMD1: begin
                    if (bc_done) begin
                        if (op_r == FCI_OP_ERASE) begin
                            // confirm in the same block
                            DQ_O <= {8'h00, `FCI_CMD_CONFIRM}; // R9
                            A_O <= addr_r; // R9
                            cyc_start_r <= 1'b1;
                            st_r <= H_CMD2;
                        end else if (op_r == FCI_OP_PROGRAM) begin
                            DQ_O <= wdat_r; // R18
                            A_O <= addr_r; // R18
                            cyc_start_r <= 1'b1;
                            st_r <= H_CMD2;
                        end else if (op_r == FCI_OP_READ_ARRAY || op_r == FCI_OP_READ_ID
                                     || op_r == FCI_OP_READ_STATUS) begin
                            // one read in the newly entered mode
                            cyc_kind_r <= FCI_CYC_READ; // R3
                            cyc_start_r <= 1'b1;
                            st_r <= H_READ;
                        end else begin
                            BUSY_O <= 1'b0;
                            DONE_O <= 1'b1;
                            st_r <= H_IDLE;
                        end
                    end
                end
                H_CMD2: begin
                    // device now returns status; poll it
                    if (bc_done) begin
                        cyc_kind_r <= FCI_CYC_READ; // R12
                        cyc_start_r <= 1'b1;
                        st_r <= H_POLL_RD;
                    end
                end
                H_READ: begin
                    if (bc_done) begin
                        RDATA_O <= bc_rd;
                        if (op_r == FCI_OP_READ_STATUS) begin
                            STATUS_O <= sr_byte; // R4
                        end
                        BUSY_O <= 1'b0;
                        DONE_O <= 1'b1;
                        st_r <= H_IDLE;
                    end
                end
                H_POLL_CMD: begin
                    // fresh read: strobe went high in between
                    cyc_start_r <= 1'b1; // R5
                    st_r <= H_POLL_RD;
                end
                default: begin
                    if (bc_done) begin
                        STATUS_O <= sr_byte;
                        if (sr_ready) begin
                            // report erase/program failure flags
                            ERR_O <= sr_err; // R22
                            RDATA_O <= bc_rd;
                            BUSY_O <= 1'b0;
                            DONE_O <= 1'b1;
                            st_r <= H_IDLE;
                        end else begin
                            st_r <= H_POLL_CMD;
                        end
                    end
                end
            endcase
        end
    end
endmodule

// ==== fci_host_assertions.sv ====
// concurrent checks on the flash command host pins and user handshake
// assumes binding onto fci_host; one clock domain, reset ARST_N_I active low
`timescale 1ns/1ps
module fci_host_chk
    import fci_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic ARST_N_I,
    input wire logic REQ_I,
    input wire logic BUSY_O,
    input wire logic DONE_O,
    input wire logic [7:0] STATUS_O,
    input wire logic FLASH_BUSY_O,
    input wire logic READY_BUSY_OUTPUT_N_I,
    input wire logic [15:0] DQ_O,
    input wire logic DQ_OE_O,
    input wire logic [19:0] A_O,
    input wire logic CE_N_O,
    input wire logic OE_N_O,
    input wire logic WE_N_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    // read and write strobes never overlap
    no_overlap_a: assert property (!(!OE_N_O && !WE_N_O))
        else $error("read and write strobes low together");
    // host never drives dq while the flash may drive it
    dq_contention_a: assert property (!OE_N_O |-> !DQ_OE_O)
        else $error("host drives dq during a read");
    // write strobe low for one full phase
    we_width_a: assert property ($fell(WE_N_O) |-> (!WE_N_O) [*7] ##1 WE_N_O)
        else $error("write strobe width wrong");
    // write strobe rises first, chip select follows a phase later
    ce_after_we_a: assert property ($rose(WE_N_O) |-> (!CE_N_O) [*7] ##1 CE_N_O)
        else $error("chip select not held past write strobe");
    // latched address and data steady while write strobe low
    write_stable_a: assert property (!WE_N_O |-> $stable(DQ_O) && $stable(A_O) && DQ_OE_O)
        else $error("address or data moved during write strobe");
    // done is a single cycle pulse, busy already dropped with it
    done_pulse_a: assert property ($rose(DONE_O) |-> !BUSY_O ##1 !DONE_O)
        else $error("done longer than one cycle");
    // idle request is taken on the next edge
    req_taken_a: assert property (REQ_I && !BUSY_O |=> BUSY_O)
        else $error("request not taken");
    // ready/busy pin mirrored within the sync delay
    busy_mirror_a: assert property ((!READY_BUSY_OUTPUT_N_I) [*5] |-> FLASH_BUSY_O)
        else $error("flash busy not mirrored");
    ready_mirror_a: assert property (READY_BUSY_OUTPUT_N_I [*5] |-> !FLASH_BUSY_O)
        else $error("flash ready not mirrored");
    // status byte shows ready and clean after reset
    wake_status_a: assert property ($rose(ARST_N_I) |-> STATUS_O == 8'h80)
        else $error("status after reset not 80");
endmodule

bind fci_host fci_host_chk fci_host_chk_inst (.REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I),
    .REQ_I(REQ_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O), .STATUS_O(STATUS_O),
    .FLASH_BUSY_O(FLASH_BUSY_O), .READY_BUSY_OUTPUT_N_I(READY_BUSY_OUTPUT_N_I), .DQ_O(DQ_O), .DQ_OE_O(DQ_OE_O),
    .A_O(A_O), .CE_N_O(CE_N_O), .OE_N_O(OE_N_O), .WE_N_O(WE_N_O));

// ==== fci_flash_model.sv ====
// behavioural boot-block flash: command decoder, status byte, timed erase/program
// assumes host strobes; ready/busy has a pull-up so floating reads high
`timescale 1ns/1ps
module fci_flash_model #(
    parameter logic [7:0] MAKER = 8'hA5, // arbitrary value
    parameter logic [7:0] DEVICE = 8'h3C, // arbitrary value
    parameter logic [7:0] SUSP = 8'h5A, // arbitrary value
    parameter int BUSY_NS = 3000 // internal operation time
)
(
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic [19:0] a_i,
    input wire logic [15:0] dq_i,
    input wire logic dq_oe_i,
    input wire logic vpp_low_i,
    input wire logic wp_n_i,
    output logic [15:0] dq_o,
    output logic ready_busy_output_n_o
);
    logic [15:0] mem [logic [19:0]]; // written words
    logic [7:0] sr = 8'h80; // ready, no errors at power-up
    logic [7:0] srl = 8'h80; // status as captured by the read strobe
    logic [1:0] mode = 2'd0; // 0 array 1 ident 2 status
    logic [7:0] pend = 8'h00; // setup code awaiting second write
    logic busy = 1'b0;
    logic susp = 1'b0;
    logic [15:0] last = 16'h0000;
    wire wr_edge = we_n_i | ce_n_i; // first rising strobe latches
    wire rd_edge = oe_n_i | ce_n_i;
    // pin floats high unless an operation runs
    assign ready_busy_output_n_o = (busy && !susp) ? 1'b0 : 1'b1;
    task automatic run(input logic [19:0] a, input bit er, input logic [15:0] d);
        busy = 1'b1;
        sr[7] = 1'b0;
        repeat (BUSY_NS / 10) begin
            #10;
            wait (!susp);
        end
        if (er) begin
            for (int i = 0; i < 4096; i++) mem[{a[19:12], 12'(i)}] = 16'hFFFF;
        end else begin
            mem[a] = d;
        end
        busy = 1'b0;
        sr[7] = 1'b1;
    endtask
    task automatic cmd(input logic [19:0] a, input logic [15:0] d);
        if (pend == 8'h20) begin
            pend = 8'h00;
            mode = 2'd2;
            if (d[7:0] != 8'hD0) sr |= 8'h30;
            else if (vpp_low_i) sr |= 8'h28;
            else if (!wp_n_i && a[19:13] == 7'h7F) sr |= 8'h22;
            else fork run(a, 1'b1, d); join_none
        end else if (pend != 8'h00) begin
            pend = 8'h00;
            mode = 2'd2;
            if (vpp_low_i) sr |= 8'h18;
            else if (!wp_n_i && a[19:13] == 7'h7F) sr |= 8'h12;
            else fork run(a, 1'b0, d); join_none
        end else begin
            case (d[7:0])
                8'hFF: if (!busy || susp) mode = 2'd0;
                8'h90: mode = 2'd1;
                8'h70: mode = 2'd2;
                8'h50: if (!susp) sr &= 8'hC5;
                8'h20, 8'h40, 8'h10: pend = d[7:0];
                8'hD0: susp = 1'b0;
                SUSP: if (busy) susp = 1'b1;
                default: ;
            endcase
        end
    endtask
    // command capture on the first rising strobe
    always @(posedge wr_edge) if (dq_oe_i === 1'b1) cmd(a_i, dq_i);
    // status captured on the falling read strobe
    always @(negedge rd_edge) srl = sr;
    always @(posedge rd_edge) last <= dq_o;
    // read data while selected, else a pattern unlike the last value
    always @(*) begin
        if (!oe_n_i && !ce_n_i) begin
            if (mode == 2'd2) dq_o = {8'h00, srl};
            else if (mode == 2'd1) dq_o = {8'h00, a_i[0] ? DEVICE : MAKER};
            else dq_o = mem.exists(a_i) ? mem[a_i] : ~a_i[15:0];
        end else begin
            dq_o = ~last;
        end
    end
endmodule

// ==== fci_host_tb.sv ====
// self-checking bench for the flash command host against the flash model
// assumes fci_host, fci_flash_model and the bound checker
`timescale 1ns/1ps
`include "fci_map.svh"
module fci_host_tb;
    import fci_pkg::*;
    logic clk, arst_n, req, ready_busy_output_n, dq_oe, ce_n, oe_n, we_n, busy, done, err, fbusy;
    logic vpp_low, wp_n, saw_fbusy;
    fci_op_t op;
    logic [19:0] addr, a;
    logic [15:0] wdata, rdata, dq_in, dq_out;
    logic [7:0] status;
    int errors = 0;
    int n_tests = 0;
    int n_cyc = 0; // cycles from request edge to done of the last op
    fci_host fci_host_inst (.REF_CLK_I(clk), .ARST_N_I(arst_n), .REQ_I(req), .OP_I(op),
        .ADDR_I(addr), .WDATA_I(wdata), .BUSY_O(busy), .DONE_O(done), .RDATA_O(rdata),
        .STATUS_O(status), .ERR_O(err), .FLASH_BUSY_O(fbusy), .READY_BUSY_OUTPUT_N_I(ready_busy_output_n),
        .DQ_I(dq_in), .DQ_O(dq_out), .DQ_OE_O(dq_oe), .A_O(a), .CE_N_O(ce_n),
        .OE_N_O(oe_n), .WE_N_O(we_n));
    fci_flash_model fci_flash_model_inst (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .a_i(a), .dq_i(dq_out), .dq_oe_i(dq_oe), .vpp_low_i(vpp_low), .wp_n_i(wp_n),
        .dq_o(dq_in), .ready_busy_output_n_o(ready_busy_output_n));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // remembers any busy indication from the pin mirror
    always @(posedge clk) if (fbusy === 1'b1) saw_fbusy = 1'b1;
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one user request, bounded wait for done
    task automatic run_op(input fci_op_t o, input logic [19:0] ad, input logic [15:0] wd);
        int n;
        @(negedge clk);
        op = o;
        addr = ad;
        wdata = wd;
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        n_cyc = n;
        check(16'(n < 2000), 16'h1, "op done");
    endtask
    task automatic t_reset;
        check({8'h00, status}, 16'h0080, "reset status");
        check({13'h0, ce_n, oe_n, we_n}, 16'h7, "idle strobes");
    endtask
    // identifier and status reads work at low supply
    task automatic t_reads;
        vpp_low = 1'b1;
        run_op(FCI_OP_READ_ID, 20'h00000, 16'h0);
        check(rdata & 16'h00FF, 16'h00A5, "maker id");
        run_op(FCI_OP_READ_ID, 20'h00001, 16'h0);
        check(rdata & 16'h00FF, 16'h003C, "device id");
        run_op(FCI_OP_READ_STATUS, 20'h9ABCD, 16'h0);
        check(rdata & 16'h00FF, 16'h0080, "status read");
        vpp_low = 1'b0;
    endtask
    // back-to-back programs then array reads
    task automatic t_program;
        run_op(FCI_OP_PROGRAM, 20'h01234, 16'hA55A);
        check({15'h0, err}, 16'h0, "program err");
        run_op(FCI_OP_PROGRAM, 20'h01235, 16'h0F0F);
        run_op(FCI_OP_READ_ARRAY, 20'h01234, 16'h0);
        check(rdata, 16'hA55A, "program word");
        run_op(FCI_OP_READ_ARRAY, 20'h01235, 16'h0);
        check(rdata, 16'h0F0F, "second word");
    endtask
    // erase one block, neighbour untouched
    task automatic t_erase;
        run_op(FCI_OP_PROGRAM, 20'h0A010, 16'h1234);
        run_op(FCI_OP_PROGRAM, 20'h0B010, 16'h5678);
        saw_fbusy = 1'b0;
        run_op(FCI_OP_ERASE, 20'h0AFFF, 16'h0);
        check({15'h0, saw_fbusy}, 16'h1, "busy seen");
        check({8'h00, status & 8'hBA}, 16'h0080, "erase status");
        run_op(FCI_OP_READ_ARRAY, 20'h0A010, 16'h0);
        check(rdata, 16'hFFFF, "erased word");
        run_op(FCI_OP_READ_ARRAY, 20'h0A000, 16'h0);
        check(rdata, 16'hFFFF, "erased base");
        run_op(FCI_OP_READ_ARRAY, 20'h0B010, 16'h0);
        check(rdata, 16'h5678, "neighbour kept");
    endtask
    // lockout errors accumulate until cleared
    task automatic t_errors;
        vpp_low = 1'b1;
        run_op(FCI_OP_ERASE, 20'h0B000, 16'h0);
        check({8'h00, status & 8'h3A}, 16'h0028, "low supply erase");
        run_op(FCI_OP_PROGRAM, 20'h0B010, 16'h0000);
        check({8'h00, status & 8'h3A}, 16'h0038, "low supply prog");
        check({15'h0, err}, 16'h1, "err flag");
        vpp_low = 1'b0;
        run_op(FCI_OP_READ_ARRAY, 20'h0B010, 16'h0);
        check(rdata, 16'h5678, "array unchanged");
        run_op(FCI_OP_CLEAR_STATUS, 20'h00000, 16'h0);
        run_op(FCI_OP_READ_STATUS, 20'h00000, 16'h0);
        check(rdata & 16'h00FF, 16'h0080, "cleared");
    endtask
    // boot block locked only with write-protect low
    task automatic t_boot;
        wp_n = 1'b0;
        run_op(FCI_OP_ERASE, 20'hFF000, 16'h0);
        check({8'h00, status & 8'h3A}, 16'h0022, "boot locked");
        run_op(FCI_OP_CLEAR_STATUS, 20'h00000, 16'h0);
        wp_n = 1'b1;
        run_op(FCI_OP_ERASE, 20'hFF000, 16'h0);
        check({15'h0, err}, 16'h0, "boot unlocked");
    endtask
    // suspend and resume are lone writes: three phases plus two register stages
    task automatic t_single;
        saw_fbusy = 1'b0;
        run_op(FCI_OP_SUSPEND, 20'h00000, 16'h0);
        check(16'(n_cyc), 16'(3 * `FCI_PHASE_CYC + 2), "suspend length");
        run_op(FCI_OP_RESUME, 20'h00000, 16'h0);
        check(16'(n_cyc), 16'(3 * `FCI_PHASE_CYC + 2), "resume length");
        check({15'h0, saw_fbusy}, 16'h0, "idle stays ready");
        run_op(FCI_OP_READ_STATUS, 20'h00000, 16'h0);
        check(rdata & 16'h00FF, 16'h0080, "status after resume");
    endtask
    task automatic complete_run;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #300_000;
        errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        complete_run;
    end
    initial begin
        arst_n = 1'b0;
        req = 1'b0;
        op = FCI_OP_READ_ARRAY;
        addr = 20'h00000;
        wdata = 16'h0000;
        vpp_low = 1'b0;
        wp_n = 1'b1;
        saw_fbusy = 1'b0;
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_reset;
        t_reads;
        t_program;
        t_erase;
        t_errors;
        t_boot;
        t_single;
        complete_run;
    end
endmodule
